/* adc_soc_pkg.sv */
package adc_soc_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] MASK_OFFSET = 8'h08;
   localparam logic [7:0] INFO_OFFSET = 8'h0c;

   // Control register fields.
   localparam int SRC_LSB = 0;
   localparam int SRC_MSB = 2;
   localparam int TRACK_MODE_BIT = 3;
   localparam int BUSY_BIT = 4;

   // Status and mask register fields.
   localparam int DONE_BIT = 0;
   localparam int WIN_BIT = 1;

   // Reset values.
   localparam logic [2:0] SRC_RESET = 3'h0;
   localparam logic TRACK_MODE_RESET = 1'b0;
   localparam logic [1:0] MASK_RESET = 2'h0;

   // -----------------------------------------------------------------
   // Start source codes
   // -----------------------------------------------------------------
   localparam logic [2:0] SRC_SOFTWARE = 3'h0;
   localparam logic [2:0] SRC_TIMER0 = 3'h1;
   localparam logic [2:0] SRC_TIMER2 = 3'h2;
   localparam logic [2:0] SRC_TIMER1 = 3'h3;
   localparam logic [2:0] SRC_EXT_PIN = 3'h4;
   localparam logic [2:0] SRC_TIMER3 = 3'h5;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CORE_CLK_PERIOD_NS = 50;
   localparam int SAR_CLK_PERIOD_NS = 100;
   localparam int SAR_DIV_INT = (SAR_CLK_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
   localparam logic [7:0] SAR_DIV = SAR_DIV_INT[7:0];
   localparam logic [7:0] TRACK_SAR_CLOCKS = 8'h03;
   localparam logic [7:0] CONV_SAR_CLOCKS = 8'h0b;

   typedef enum {SEQ_IDLE, SEQ_TRACK, SEQ_CONVERT} seq_state_e;

endpackage

/* sar_seq_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Load and finish handshake between the sequencer and the SAR clock counter.
interface sar_seq_if;
   logic start;
   logic [7:0] count;
   logic done;
   modport ctrl (output start, output count, input done);
   modport counter (input start, input count, output done);
endinterface

`default_nettype wire

/* sar_tick_counter.sv */
`timescale 1ns/1ps
`default_nettype none

// Derives the SAR clock enable from the core clock and counts a loaded
// number of SAR clocks, pulsing done on the last one.
module sar_tick_counter
   import adc_soc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   sar_seq_if.counter seq
);

   logic [7:0] div_r;
   logic [7:0] div_nxt;
   logic [7:0] left_r;
   logic [7:0] left_nxt;
   logic tick;

   // -----------------------------------------------------------------
   // Divider and down counter
   // -----------------------------------------------------------------

   // The divider restarts on each load so every period is a whole SAR clock.
   always_comb begin
      tick = (div_r == SAR_DIV - 8'h01) && (left_r != 8'h00);
      div_nxt = div_r;
      left_nxt = left_r;
      seq.done = tick && (left_r == 8'h01);
      if (seq.start) begin
         div_nxt = 8'h00;
         left_nxt = seq.count;
      end else if (left_r != 8'h00) begin
         if (tick) begin
            div_nxt = 8'h00;
            left_nxt = left_r - 8'h01;
         end else begin
            div_nxt = div_r + 8'h01;
         end
      end
   end

   // Registers only.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         div_r <= 8'h00;
         left_r <= 8'h00;
      end else begin
         div_r <= div_nxt;
         left_r <= left_nxt;
      end
   end

endmodule

`default_nettype wire

/* adc_start_of_conversion_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_start_of_conversion_ctrl
   import adc_soc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_timer0_ovf,
   input wire logic i_timer1_ovf,
   input wire logic i_timer2_ovf,
   input wire logic i_timer3_ovf,
   input wire logic i_window_match,
   input wire logic i_ext_convert_start_pin,
   output logic o_conv_in_progress,
   output logic o_tracking,
   output logic o_converting,
   output logic o_irq
);

   sar_seq_if seq ();

   logic [2:0] src_r;
   logic [2:0] src_nxt;
   logic track_mode_r;
   logic track_mode_nxt;
   logic [1:0] status_r;
   logic [1:0] status_nxt;
   logic [1:0] mask_r;
   logic [1:0] mask_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pin_meta_r;
   logic pin_sync_r;
   logic pin_prev_r;
   seq_state_e state_r;
   seq_state_e state_nxt;
   logic tracking_r;
   logic tracking_nxt;
   logic converting_r;
   logic converting_nxt;
   logic busy_r;
   logic busy_nxt;
   logic wr_access;
   logic setup;
   logic mapped;
   logic sw_start;
   logic trigger;
   logic pin_rise;
   logic busy_fall;

   // -----------------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------------

   // Zero wait states; unmapped addresses answer with an error.
   always_comb begin
      setup = i_psel && !i_penable;
      wr_access = i_psel && i_penable && i_pwrite;
      mapped = (i_paddr == CTRL_OFFSET) || (i_paddr == STATUS_OFFSET) ||
               (i_paddr == MASK_OFFSET) || (i_paddr == INFO_OFFSET);
      o_pready = 1'b1;
      o_pslverr = i_psel && i_penable && !mapped;
      o_prdata = prdata_r;
   end

   // Read data is captured in the setup cycle so it comes from a flop.
   always_comb begin
      prdata_nxt = prdata_r;
      if (setup && !i_pwrite) begin
         prdata_nxt = 32'h0000_0000;
         case (i_paddr)
            CTRL_OFFSET: begin
               prdata_nxt[SRC_MSB:SRC_LSB] = src_r;
               prdata_nxt[TRACK_MODE_BIT] = track_mode_r;
               prdata_nxt[BUSY_BIT] = busy_r;
            end
            STATUS_OFFSET: begin
               prdata_nxt[WIN_BIT:DONE_BIT] = status_r;
            end
            MASK_OFFSET: begin
               prdata_nxt[WIN_BIT:DONE_BIT] = mask_r;
            end
            INFO_OFFSET: begin
               prdata_nxt[7:0] = CONV_SAR_CLOCKS;
               prdata_nxt[15:8] = TRACK_SAR_CLOCKS;
            end
            default: begin
               prdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Control, status and mask registers
   // -----------------------------------------------------------------

   // Status bits are write-one-to-clear; a new event in the same cycle wins.
   always_comb begin
      src_nxt = src_r;
      track_mode_nxt = track_mode_r;
      mask_nxt = mask_r;
      status_nxt = status_r;
      sw_start = 1'b0;
      if (wr_access && (i_paddr == CTRL_OFFSET)) begin
         src_nxt = i_pwdata[SRC_MSB:SRC_LSB];
         track_mode_nxt = i_pwdata[TRACK_MODE_BIT];
         sw_start = i_pwdata[BUSY_BIT] && (src_r == SRC_SOFTWARE);
      end
      if (wr_access && (i_paddr == MASK_OFFSET)) begin
         mask_nxt = i_pwdata[WIN_BIT:DONE_BIT];
      end
      if (wr_access && (i_paddr == STATUS_OFFSET)) begin
         status_nxt = status_r & ~i_pwdata[WIN_BIT:DONE_BIT];
      end
      if (i_window_match) begin
         status_nxt[WIN_BIT] = 1'b1;
      end
      if (busy_fall) begin
         status_nxt[DONE_BIT] = 1'b1;
      end
   end

   // Registers only.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         src_r <= SRC_RESET;
         track_mode_r <= TRACK_MODE_RESET;
         mask_r <= MASK_RESET;
         status_r <= 2'h0;
         prdata_r <= 32'h0000_0000;
      end else begin
         src_r <= src_nxt;
         track_mode_r <= track_mode_nxt;
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // Level interrupt while any unmasked status bit is set.
   always_comb begin
      o_irq = |(status_r & mask_r);
   end

   // -----------------------------------------------------------------
   // Pin synchroniser
   // -----------------------------------------------------------------

   // Two flops before any logic; the third only feeds the edge detector.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         pin_meta_r <= 1'b1;
         pin_sync_r <= 1'b1;
         pin_prev_r <= 1'b1;
      end else begin
         pin_meta_r <= i_ext_convert_start_pin;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // -----------------------------------------------------------------
   // Trigger selection
   // -----------------------------------------------------------------

   // Timer overflows are single-cycle pulses from logic on this clock.
   always_comb begin
      pin_rise = pin_sync_r && !pin_prev_r;
      case (src_r)
         SRC_SOFTWARE: trigger = sw_start;
         SRC_TIMER0: trigger = i_timer0_ovf;
         // Timer 2, Timer 1 and pin codes
         SRC_TIMER2: trigger = i_timer2_ovf;
         SRC_TIMER1: trigger = i_timer1_ovf;
         SRC_EXT_PIN: trigger = pin_rise;
         SRC_TIMER3: trigger = i_timer3_ovf;
         default: trigger = 1'b0;
      endcase
   end

   // -----------------------------------------------------------------
   // Conversion sequencer
   // -----------------------------------------------------------------

   // The pin source always converts on the edge: its tracking was the low phase.
   always_comb begin
      state_nxt = state_r;
      seq.start = 1'b0;
      seq.count = CONV_SAR_CLOCKS;
      busy_fall = 1'b0;
      case (state_r)
         SEQ_IDLE: begin
            if (trigger) begin
               seq.start = 1'b1;
               if (track_mode_r && (src_r != SRC_EXT_PIN)) begin
                  // Timer 0 then 3 SAR clocks
                  // Timer 2 then 3 SAR clocks
                  // Timer 3 then 3 SAR clocks
                  seq.count = TRACK_SAR_CLOCKS;
                  state_nxt = SEQ_TRACK;
               end else begin
                  state_nxt = SEQ_CONVERT;
               end
            end
         end
         SEQ_TRACK: begin
            // Tracking done, conversion follows at once.
            if (seq.done) begin
               seq.start = 1'b1;
               state_nxt = SEQ_CONVERT;
            end
         end
         SEQ_CONVERT: begin
            if (seq.done) begin
               busy_fall = 1'b1;
               state_nxt = SEQ_IDLE;
            end
         end
         default: begin
            state_nxt = SEQ_IDLE;
         end
      endcase
   end

   // Output levels follow the next state so they line up with busy.
   always_comb begin
      busy_nxt = (state_nxt != SEQ_IDLE);
      converting_nxt = (state_nxt == SEQ_CONVERT);
      tracking_nxt = (state_nxt == SEQ_TRACK) ||
                     ((state_nxt == SEQ_IDLE) && (src_nxt == SRC_EXT_PIN) && !pin_sync_r);
   end

   // Registers only.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_r <= SEQ_IDLE;
         busy_r <= 1'b0;
         tracking_r <= 1'b0;
         converting_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy_r <= busy_nxt;
         tracking_r <= tracking_nxt;
         converting_r <= converting_nxt;
      end
   end

   always_comb begin
      o_conv_in_progress = busy_r;
      o_tracking = tracking_r;
      o_converting = converting_r;
   end

   // Divider and SAR clock counter.
   sar_tick_counter u_counter (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .seq(seq.counter)
   );

endmodule

`default_nettype wire

/* adc_soc_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the block ports and mirrors the writable fields it needs.
module adc_soc_ctrl_checker
   import adc_soc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic i_timer0_ovf,
   input wire logic i_timer1_ovf,
   input wire logic i_timer2_ovf,
   input wire logic i_timer3_ovf,
   input wire logic i_window_match,
   input wire logic o_conv_in_progress,
   input wire logic o_tracking,
   input wire logic o_converting,
   input wire logic o_irq
);
   logic [2:0] src_r;
   logic tm_r;
   logic [1:0] mask_r;
   logic [5:0] len_r;
   logic wr;
   logic ctl_wr;
   logic sel_ovf;
   logic sw_go;
   // Mirror copies use the old source value, as the block does.
   assign wr = i_psel & i_penable & i_pwrite;
   assign ctl_wr = wr && (i_paddr == CTRL_OFFSET);
   assign sel_ovf = (src_r == SRC_TIMER0) ? i_timer0_ovf : (src_r == SRC_TIMER1) ? i_timer1_ovf :
                    (src_r == SRC_TIMER2) ? i_timer2_ovf : (src_r == SRC_TIMER3) ? i_timer3_ovf : 1'b0;
   assign sw_go = ctl_wr && i_pwdata[BUSY_BIT] && (src_r == SRC_SOFTWARE) && !o_conv_in_progress;
   // Busy length counter and field mirrors.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         src_r <= SRC_RESET;
         tm_r <= TRACK_MODE_RESET;
         mask_r <= MASK_RESET;
         len_r <= 6'h00;
      end else begin
         if (ctl_wr) begin
            src_r <= i_pwdata[SRC_MSB:SRC_LSB];
            tm_r <= i_pwdata[TRACK_MODE_BIT];
         end
         if (wr && (i_paddr == MASK_OFFSET)) begin
            mask_r <= i_pwdata[WIN_BIT:DONE_BIT];
         end
         len_r <= o_conv_in_progress ? len_r + 6'h01 : 6'h00;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // Three SAR clocks of tracking, then conversion.
   sequence track_then_conv;
      o_tracking[*6] ##1 o_converting;
   endsequence
   a_conv_in_busy: assert property (o_converting |-> o_conv_in_progress)
      else $error("converting without busy");
   a_sw_immediate: assert property (sw_go && !tm_r |=> o_converting && !o_tracking)
      else $error("software start did not convert");
   a_sw_delayed: assert property (sw_go && tm_r |=> track_then_conv)
      else $error("software delayed start wrong");
   a_timer_start: assert property (sel_ovf && !o_conv_in_progress && !tm_r |=> o_converting)
      else $error("timer start did not convert");
   a_timer_track: assert property (sel_ovf && !o_conv_in_progress && tm_r |=> track_then_conv)
      else $error("timer delayed start wrong");
   a_start_refused: assert property (ctl_wr && !sw_go && !sel_ovf && !o_conv_in_progress
      && src_r != SRC_EXT_PIN |=> !o_conv_in_progress)
      else $error("start write not refused");
   a_reserved_idle: assert property (src_r[2:1] == 2'h3 && !o_conv_in_progress |=> !o_conv_in_progress)
      else $error("reserved source started");
   a_busy_length: assert property ($fell(o_conv_in_progress) |-> len_r == 6'h16 || len_r == 6'h1c)
      else $error("busy length wrong");
   a_done_irq: assert property ($fell(o_conv_in_progress) && mask_r[DONE_BIT] |-> o_irq)
      else $error("done did not raise irq");
   a_window_irq: assert property (i_window_match && mask_r[WIN_BIT] |=> o_irq)
      else $error("window match did not raise irq");
   a_irq_sticky: assert property (o_irq && !wr |=> o_irq)
      else $error("irq dropped without a write");
endmodule
bind adc_start_of_conversion_ctrl adc_soc_ctrl_checker u_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .i_timer0_ovf(i_timer0_ovf), .i_timer1_ovf(i_timer1_ovf), .i_timer2_ovf(i_timer2_ovf),
   .i_timer3_ovf(i_timer3_ovf), .i_window_match(i_window_match), .o_conv_in_progress(o_conv_in_progress),
   .o_tracking(o_tracking), .o_converting(o_converting), .o_irq(o_irq));
`default_nettype wire

/* adc_start_of_conversion_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_start_of_conversion_ctrl_test;
   import adc_soc_pkg::*;
   logic clk, rst, psel, penable, pwrite, pin, win, pready, pslverr, busy, trk, cnv, irq, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] tmr;
   int fail_count, check_count, n, t, v;
   adc_start_of_conversion_ctrl i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_timer0_ovf(tmr[0]), .i_timer1_ovf(tmr[1]), .i_timer2_ovf(tmr[2]),
      .i_timer3_ovf(tmr[3]), .i_window_match(win), .i_ext_convert_start_pin(pin),
      .o_conv_in_progress(busy), .o_tracking(trk), .o_converting(cnv), .o_irq(irq));
   // -----------------------------------------------------------------
   // Bus, pulse and report tasks
   // -----------------------------------------------------------------
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // The slave may stretch the access phase; only the watchdog ends this wait.
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata; e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, x, s);
      end
   endtask
   // Bit 4 drives the window match, bits 3:0 the timer overflows.
   task automatic pulse(input logic [4:0] v);
      @(posedge clk); tmr <= v[3:0]; win <= v[4];
      @(posedge clk); tmr <= 4'h0; win <= 1'b0;
   endtask
   // Counts settled cycles with busy high, with tracking high and with converting high.
   task automatic len();
      n = 0; t = 0; v = 0; #1;
      while (busy === 1'b1 && n < 100) begin
         n++; t += (trk === 1'b1); v += (cnv === 1'b1);
         @(posedge clk); #1;
      end
   endtask
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", fail_count, check_count);
      if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_regs();
      apb(0, INFO_OFFSET, 0); chk("info", q, {16'h0, TRACK_SAR_CLOCKS, CONV_SAR_CLOCKS});
      apb(0, 8'h10, 0); chk("unmapped err", e, 1); chk("unmapped data", q, 0);
      apb(0, MASK_OFFSET, 0); chk("mask reset", q, 0);
   endtask
   task automatic t_soft();
      apb(1, MASK_OFFSET, 1); apb(1, CTRL_OFFSET, 0); #1; chk("zero write busy", busy, 0);
      apb(1, CTRL_OFFSET, 32'h10); len(); chk("imm length", n, 22); chk("imm track", t, 0);
      chk("imm convert", v, 22);
      chk("done irq", irq, 1); apb(0, STATUS_OFFSET, 0); chk("done flag", q, 1);
      apb(1, STATUS_OFFSET, 1); #1; chk("irq cleared", irq, 0);
      apb(1, CTRL_OFFSET, 32'h10); apb(0, CTRL_OFFSET, 0); chk("busy read", q, 32'h10); len();
      apb(1, CTRL_OFFSET, 32'h08); apb(1, CTRL_OFFSET, 32'h18); len(); chk("dly length", n, 28);
      chk("dly track", t, 6);
      chk("dly convert", v, 22);
   endtask
   task automatic t_timers();
      logic [2:0] code [4];
      int idx [4];
      code = '{SRC_TIMER0, SRC_TIMER2, SRC_TIMER1, SRC_TIMER3};
      idx = '{0, 2, 1, 3};
      for (int i = 0; i < 8; i++) begin
         apb(1, CTRL_OFFSET, {28'h0, i[2], code[i % 4]});
         apb(1, CTRL_OFFSET, {28'h1, i[2], code[i % 4]}); #1; chk("src start refused", busy, 0);
         pulse(5'h1 << ((idx[i % 4] + 1) % 4)); #1; chk("other timer", busy, 0);
         pulse(5'h1 << idx[i % 4]); pulse(5'h1 << idx[i % 4]); len();
         chk("timer length", n, i[2] ? 26 : 20); chk("timer track", t, i[2] ? 4 : 0);
      end
      for (int c = 6; c < 8; c++) begin
         apb(1, CTRL_OFFSET, c); pulse(5'h0f); apb(1, CTRL_OFFSET, c + 16); #1;
         chk("reserved busy", busy, 0);
      end
   endtask
   // Runs the pin source in both tracking modes; busy is looked at only once it has settled.
   task automatic t_pin();
      for (int m = 0; m < 2; m++) begin
         apb(1, CTRL_OFFSET, {28'h0, m[0], SRC_EXT_PIN}); pin <= 0; repeat (6) @(posedge clk); #1;
         chk("pin low track", trk, 1); chk("pin low busy", busy, 0);
         @(posedge clk); pin <= 1; #1;
         for (int k = 0; k < 8 && busy !== 1'b1; k++) begin
            @(posedge clk); #1;
         end
         len(); chk("pin length", n, 22); chk("pin track", t, 0);
      end
   endtask
   task automatic t_win();
      apb(1, STATUS_OFFSET, 3); apb(1, MASK_OFFSET, 2); #1; chk("irq idle", irq, 0);
      pulse(5'h10); repeat (3) @(posedge clk); #1; chk("win irq", irq, 1);
      apb(0, STATUS_OFFSET, 0); chk("win flag", q, 2);
      apb(1, STATUS_OFFSET, 2); apb(0, STATUS_OFFSET, 0); chk("win cleared", q, 0);
   endtask
   // -----------------------------------------------------------------
   // Main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      pin = 1; win = 0; tmr = 0; fail_count = 0; check_count = 0;
      repeat (8) @(posedge clk);
      rst <= 0;
      t_regs(); t_soft(); t_timers(); t_pin(); t_win();
      close_out();
   end
   // The scenarios need well under two thousand cycles; this allows ten thousand.
   initial begin
      #500000;
      fail_count++;
      close_out();
   end
endmodule
`default_nettype wire
